/* File: hdl/tfr_top.sv */
// Purpose: Over-temperature limits, warnings and fault response
// Assumes: Commands arrive already decoded from the management bus
// Notes:   Temperature and enable come from logic on SYS_CLK_I
`timescale 1ns/1ps
`include "tfr_regs.svh"
`default_nettype none

module tfr_top
   import tfr_pkg::*;
#(
   parameter int unsigned UNIT_CYCLES = `TFR_UNIT_CYCLES
) (
   input  wire logic        SYS_CLK_I,
   input  wire logic        RST_B_I,
   input  wire logic        CMD_VALID_I,
   input  wire logic        CMD_WRITE_I,
   input  wire logic [7:0]  CMD_CODE_I,
   input  wire logic [15:0] CMD_WDATA_I,
   input  wire logic [15:0] TEMP_I,
   input  wire logic        ENABLE_REQ_I,
   input  wire logic        OTHER_FAULT_I,
   output logic [15:0]      RDATA_O,
   output logic             RDATA_VALID_O,
   output logic             OUTPUT_EN_O,
   output logic             OT_FAULT_O,
   output logic             OT_WARN_O,
   output logic             UT_WARN_O
);

   // Configuration registers
   tfr_thr_type   thr_q;
   tfr_thr_type   thr_d;
   logic [7:0]    act_q;
   logic [7:0]    act_d;

   // Status and readback
   logic [7:0]    sts_q;
   logic [7:0]    sts_d;
   logic [15:0]   rdata_d;
   logic          rvalid_d;

   // Fault response state
   tfr_state_type state_q;
   tfr_state_type state_d;
   logic [2:0]    tries_q;
   logic [2:0]    tries_d;
   logic          en_q;
   logic          out_d;

   tfr_flags_type flags;
   logic          timer_start;
   logic          timer_done;
   logic          wr;
   logic          rd;
   logic          clr_all;
   logic          clr_ot;
   logic          clear_evt;
   logic          run_en;
   logic [1:0]    sel;
   logic [2:0]    retry;

   assign wr    = CMD_VALID_I & CMD_WRITE_I;
   assign rd    = CMD_VALID_I & ~CMD_WRITE_I;
   assign sel   = act_q[`TFR_ACT_SEL];
   assign retry = act_q[`TFR_ACT_RETRY];

   tfr_temp_compare u_cmp (
      .clk_i   (SYS_CLK_I),
      .rst_b_i (RST_B_I),
      .temp_i  (TEMP_I),
      .thr_i   (thr_q),
      .flags_o (flags)
   );

   tfr_delay_timer #(
      .UNIT_CYCLES (UNIT_CYCLES)
   ) u_tmr (
      .clk_i   (SYS_CLK_I),
      .rst_b_i (RST_B_I),
      .start_i (timer_start),
      .code_i  (act_q[`TFR_ACT_DELAY]),
      .done_o  (timer_done)
   );

   // Limit and action registers
   always_comb begin
      thr_d = thr_q;
      act_d = act_q;
      if (wr) begin
         unique case (CMD_CODE_I)
            `TFR_CMD_OT_FAULT_THR: thr_d.ot_fault = CMD_WDATA_I;
            `TFR_CMD_OT_WARN_THR:  thr_d.ot_warn  = CMD_WDATA_I;
            `TFR_CMD_UT_WARN_THR:  thr_d.ut_warn  = CMD_WDATA_I;
            `TFR_CMD_OT_FAULT_ACT: act_d = CMD_WDATA_I[7:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         thr_q.ot_fault <= `TFR_RST_OT_FAULT_THR;
         thr_q.ot_warn  <= `TFR_RST_OT_WARN_THR;
         thr_q.ut_warn  <= `TFR_RST_UT_WARN_THR;
         act_q          <= `TFR_RST_ACTION;
      end else begin
         thr_q <= thr_d;
         act_q <= act_d;
      end
   end

   // Clear sources: clear command, status write, off request
   assign clr_all   = wr & (CMD_CODE_I == `TFR_CMD_CLEAR_FAULTS);
   assign clr_ot    = wr & (CMD_CODE_I == `TFR_CMD_STATUS_TEMP)
                      & CMD_WDATA_I[`TFR_STS_OT_FAULT];
   assign clear_evt = clr_all | clr_ot | (en_q & ~ENABLE_REQ_I);
   assign run_en    = ENABLE_REQ_I & ~OTHER_FAULT_I;

   // Sticky status, a new event wins over a clear
   always_comb begin
      sts_d = sts_q;
      if (clr_all) begin
         sts_d = '0;
      end else if (wr && CMD_CODE_I == `TFR_CMD_STATUS_TEMP) begin
         sts_d = sts_q & ~CMD_WDATA_I[7:0];
      end
      if (flags.ot_fault) begin
         sts_d[`TFR_STS_OT_FAULT] = 1'b1;
      end
      if (flags.ot_warn) begin
         sts_d[`TFR_STS_OT_WARN] = 1'b1;
      end
      if (flags.ut_warn) begin
         sts_d[`TFR_STS_UT_WARN] = 1'b1;
      end
   end

   // Readback, unknown codes read as zero
   always_comb begin
      rvalid_d = rd;
      rdata_d  = '0;
      if (rd) begin
         unique case (CMD_CODE_I)
            `TFR_CMD_OT_FAULT_THR: rdata_d = thr_q.ot_fault;
            `TFR_CMD_OT_WARN_THR:  rdata_d = thr_q.ot_warn;
            `TFR_CMD_UT_WARN_THR:  rdata_d = thr_q.ut_warn;
            `TFR_CMD_OT_FAULT_ACT: rdata_d = {8'h00, act_q};
            `TFR_CMD_STATUS_TEMP:  rdata_d = {8'h00, sts_q};
            default: rdata_d = '0;
         endcase
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         sts_q         <= '0;
         RDATA_O       <= '0;
         RDATA_VALID_O <= 1'b0;
         OT_FAULT_O    <= 1'b0;
         OT_WARN_O     <= 1'b0;
         UT_WARN_O     <= 1'b0;
      end else begin
         sts_q         <= sts_d;
         RDATA_O       <= rdata_d;
         RDATA_VALID_O <= rvalid_d;
         OT_FAULT_O    <= sts_d[`TFR_STS_OT_FAULT];
         OT_WARN_O     <= sts_d[`TFR_STS_OT_WARN];
         UT_WARN_O     <= sts_d[`TFR_STS_UT_WARN];
      end
   end

   // Fault response machine
   always_comb begin
      state_d     = state_q;
      tries_d     = tries_q;
      timer_start = 1'b0;
      unique case (state_q)
         ST_RUN: begin
            if (run_en && flags.ot_fault) begin
               unique case (sel)
                  `TFR_SEL_IGNORE: ;
                  `TFR_SEL_DELAYED: begin
                     state_d     = ST_DELAY;
                     timer_start = 1'b1;
                  end
                  `TFR_SEL_DIS_RETRY: begin
                     tries_d = '0;
                     if (retry == `TFR_RETRY_NONE) begin
                        state_d = ST_LATCH;
                     end else begin
                        state_d     = ST_RETRY;
                        timer_start = 1'b1;
                     end
                  end
                  `TFR_SEL_DIS_LATCH: state_d = ST_LATCH;
               endcase
            end
         end
         ST_DELAY: begin
            if (!ENABLE_REQ_I) begin
               state_d = ST_RUN;
            end else if (OTHER_FAULT_I) begin
               state_d = ST_LATCH;
            end else if (timer_done) begin
               tries_d = '0;
               if (!flags.ot_fault) begin
                  state_d = ST_RUN;
               end else if (retry == `TFR_RETRY_NONE) begin
                  state_d = ST_LATCH;
               end else begin
                  state_d     = ST_RETRY;
                  timer_start = 1'b1;
               end
            end
         end
         ST_RETRY: begin
            if (!ENABLE_REQ_I) begin
               state_d = ST_RUN;
            end else if (OTHER_FAULT_I) begin
               state_d = ST_LATCH;
            end else if (timer_done) begin
               tries_d = tries_q + 3'h1;
               if (!flags.ot_fault) begin
                  state_d = ST_RUN;
               end else if (retry != `TFR_RETRY_FOREVER &&
                            tries_q + 3'h1 >= retry) begin
                  state_d = ST_LATCH;
               end else begin
                  timer_start = 1'b1;
               end
            end
         end
         ST_LATCH: begin
            if (clear_evt) begin
               state_d = ST_RUN;
            end
         end
      endcase
   end

   // Output stays on only while running or in the run-on delay
   assign out_d = run_en & ((state_d == ST_RUN) | (state_d == ST_DELAY));

   always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         state_q     <= ST_RUN;
         tries_q     <= '0;
         en_q        <= 1'b0;
         OUTPUT_EN_O <= 1'b0;
      end else begin
         state_q     <= state_d;
         tries_q     <= tries_d;
         en_q        <= ENABLE_REQ_I;
         OUTPUT_EN_O <= out_d;
      end
   end

endmodule // tfr_top

`default_nettype wire

/* File: hdl/tfr_regs.svh */
// Purpose: Command codes, field slices, reset values and timing constants
// Assumes: Temperatures and thresholds use the 16-bit linear number format
// Notes:   Included wherever the command codes and fields are needed
`ifndef TFR_REGS_SVH
`define TFR_REGS_SVH

// Command codes
`define TFR_CMD_CLEAR_FAULTS 8'h03
`define TFR_CMD_OT_FAULT_THR 8'h4f
`define TFR_CMD_OT_FAULT_ACT 8'h50
`define TFR_CMD_OT_WARN_THR  8'h51
`define TFR_CMD_UT_WARN_THR  8'h52
`define TFR_CMD_STATUS_TEMP  8'h7d

// Reset values
`define TFR_RST_OT_FAULT_THR 16'h007d
`define TFR_RST_OT_WARN_THR  16'h0073
`define TFR_RST_UT_WARN_THR  16'h07d8
`define TFR_RST_ACTION       8'h80

// Fault action fields
`define TFR_ACT_SEL          7:6
`define TFR_ACT_RETRY        5:3
`define TFR_ACT_DELAY        2:0
`define TFR_SEL_IGNORE       2'h0
`define TFR_SEL_DELAYED      2'h1
`define TFR_SEL_DIS_RETRY    2'h2
`define TFR_SEL_DIS_LATCH    2'h3
`define TFR_RETRY_NONE       3'h0
`define TFR_RETRY_FOREVER    3'h7

// Temperature status bits
`define TFR_STS_OT_FAULT     7
`define TFR_STS_OT_WARN      6
`define TFR_STS_UT_WARN      5

// Linear number format
`define TFR_LIN_EXP          15:11
`define TFR_LIN_MANT         10:0
`define TFR_LIN_SIGN         10

// Timing: one delay unit in ns, clock period in ns
`define TFR_UNIT_NS          10000000
`define TFR_CLK_NS           5
`define TFR_UNIT_CYCLES      ((`TFR_UNIT_NS + `TFR_CLK_NS - 1) / `TFR_CLK_NS)

`endif

/* File: hdl/tfr_pkg.sv */
// Purpose: Types and number decoding shared by the temperature fault block
// Assumes: tfr_regs.svh on the include path
// Notes:   Linear values become signed fixed point with 16 fraction bits
`include "tfr_regs.svh"

package tfr_pkg;

   typedef enum logic [3:0] {
      ST_RUN   = 4'h1,
      ST_DELAY = 4'h2,
      ST_RETRY = 4'h4,
      ST_LATCH = 4'h8
   } tfr_state_type;

   typedef struct packed {
      logic [15:0] ot_fault;
      logic [15:0] ot_warn;
      logic [15:0] ut_warn;
   } tfr_thr_type;

   typedef struct packed {
      logic ot_fault;
      logic ot_warn;
      logic ut_warn;
   } tfr_flags_type;

   // Exponent -16..15 maps to a left shift of 0..31
   function automatic logic signed [47:0] tfr_lin_to_fix(
      input logic [15:0] v);
      logic [4:0]           e;
      logic signed [47:0]   m;
      e = v[`TFR_LIN_EXP];
      m = {{37{v[`TFR_LIN_SIGN]}}, v[`TFR_LIN_MANT]};
      return m <<< {~e[4], e[3:0]};
   endfunction

endpackage

/* File: hdl/tfr_delay_timer.sv */
// Purpose: Counts two to the power of a code in delay units
// Assumes: start is a one-cycle pulse; a new start restarts the count
// Notes:   done is a registered one-cycle pulse
`timescale 1ns/1ps
`include "tfr_regs.svh"
`default_nettype none

module tfr_delay_timer
   import tfr_pkg::*;
#(
   parameter int unsigned UNIT_CYCLES = `TFR_UNIT_CYCLES
) (
   input  wire logic       clk_i,
   input  wire logic       rst_b_i,
   input  wire logic       start_i,
   input  wire logic [2:0] code_i,
   output logic            done_o
);

   logic [31:0] cyc_q;
   logic [31:0] cyc_d;
   logic [7:0]  unit_q;
   logic [7:0]  unit_d;
   logic        busy_q;
   logic        busy_d;
   logic        done_d;

   always_comb begin
      cyc_d  = cyc_q;
      unit_d = unit_q;
      busy_d = busy_q;
      done_d = 1'b0;
      if (start_i) begin
         cyc_d  = '0;
         unit_d = 8'((9'h1 << code_i) - 9'h1);
         busy_d = 1'b1;
      end else if (busy_q) begin
         if (cyc_q == UNIT_CYCLES - 1) begin
            cyc_d = '0;
            if (unit_q == 8'h0) begin
               busy_d = 1'b0;
               done_d = 1'b1;
            end else begin
               unit_d = unit_q - 8'h1;
            end
         end else begin
            cyc_d = cyc_q + 32'h1;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cyc_q  <= '0;
         unit_q <= '0;
         busy_q <= 1'b0;
         done_o <= 1'b0;
      end else begin
         cyc_q  <= cyc_d;
         unit_q <= unit_d;
         busy_q <= busy_d;
         done_o <= done_d;
      end
   end

endmodule // tfr_delay_timer

`default_nettype wire

/* File: hdl/tfr_temp_compare.sv */
// Purpose: Compares the temperature against the three thresholds
// Assumes: Temperature and thresholds in linear format, same clock
// Notes:   Flags are registered, one cycle behind the inputs
`timescale 1ns/1ps
`default_nettype none

module tfr_temp_compare
   import tfr_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_b_i,
   input  wire logic [15:0] temp_i,
   input  var  tfr_thr_type thr_i,
   output tfr_flags_type    flags_o
);

   logic signed [47:0] t;
   tfr_flags_type      flags_d;

   always_comb begin
      t = tfr_lin_to_fix(temp_i);
      flags_d.ot_fault = t > tfr_lin_to_fix(thr_i.ot_fault);
      flags_d.ot_warn  = t > tfr_lin_to_fix(thr_i.ot_warn);
      flags_d.ut_warn  = t < tfr_lin_to_fix(thr_i.ut_warn);
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         flags_o <= '0;
      end else begin
         flags_o <= flags_d;
      end
   end

endmodule // tfr_temp_compare

`default_nettype wire

/* File: test/tfr_top_assertions.sv */
// Purpose: Port assertions for the temperature fault block
// Assumes: Bound to tfr_top, sees its ports only
// Notes:   Shadow limits follow writes to predict read-back
`timescale 1ns/1ps
`include "tfr_regs.svh"
`default_nettype none

module tfr_top_assertions
   import tfr_pkg::*;
#(
   parameter int unsigned UNIT_CYCLES = 4
) (
   input wire logic        SYS_CLK_I,
   input wire logic        RST_B_I,
   input wire logic        CMD_VALID_I,
   input wire logic        CMD_WRITE_I,
   input wire logic [7:0]  CMD_CODE_I,
   input wire logic [15:0] CMD_WDATA_I,
   input wire logic [15:0] TEMP_I,
   input wire logic        ENABLE_REQ_I,
   input wire logic        OTHER_FAULT_I,
   input wire logic [15:0] RDATA_O,
   input wire logic        RDATA_VALID_O,
   input wire logic        OUTPUT_EN_O,
   input wire logic        OT_FAULT_O,
   input wire logic        OT_WARN_O,
   input wire logic        UT_WARN_O
);
   logic [15:0] flt_q, flt_d, wrn_q, wrn_d, utw_q, utw_d;
   logic [7:0]  act_q, act_d;
   logic        wr_now;

   assign wr_now = CMD_VALID_I && CMD_WRITE_I;

   always_comb begin
      flt_d = flt_q;
      wrn_d = wrn_q;
      utw_d = utw_q;
      act_d = act_q;
      if (wr_now) begin
         case (CMD_CODE_I)
            `TFR_CMD_OT_FAULT_THR: flt_d = CMD_WDATA_I;
            `TFR_CMD_OT_FAULT_ACT: act_d = CMD_WDATA_I[7:0];
            `TFR_CMD_OT_WARN_THR:  wrn_d = CMD_WDATA_I;
            `TFR_CMD_UT_WARN_THR:  utw_d = CMD_WDATA_I;
            default: ;
         endcase
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         flt_q <= `TFR_RST_OT_FAULT_THR;
         wrn_q <= `TFR_RST_OT_WARN_THR;
         utw_q <= `TFR_RST_UT_WARN_THR;
         act_q <= `TFR_RST_ACTION;
      end else begin
         flt_q <= flt_d;
         wrn_q <= wrn_d;
         utw_q <= utw_d;
         act_q <= act_d;
      end
   end

   default clocking cb @(posedge SYS_CLK_I);
   endclocking
   default disable iff (!RST_B_I);

   sequence s_read(logic [7:0] code);
      CMD_VALID_I && !CMD_WRITE_I && CMD_CODE_I == code;
   endsequence

   sequence s_any_read;
      CMD_VALID_I && !CMD_WRITE_I;
   endsequence

   a_fault_thr_read: assert property (
      s_read(`TFR_CMD_OT_FAULT_THR) |=> RDATA_O == $past(flt_q))
      else $error("fault limit read-back wrong");
   a_warn_thr_read: assert property (
      s_read(`TFR_CMD_OT_WARN_THR) |=> RDATA_O == $past(wrn_q))
      else $error("warning limit read-back wrong");
   a_ut_thr_read: assert property (
      s_read(`TFR_CMD_UT_WARN_THR) |=> RDATA_O == $past(utw_q))
      else $error("under limit read-back wrong");
   a_action_read: assert property (
      s_read(`TFR_CMD_OT_FAULT_ACT) |=> RDATA_O == {8'h00, $past(act_q)})
      else $error("action read-back wrong");
   a_read_answer: assert property (s_any_read |=> RDATA_VALID_O)
      else $error("read not answered");
   a_no_stray_valid: assert property (
      !(CMD_VALID_I && !CMD_WRITE_I) |=> !RDATA_VALID_O)
      else $error("read valid without read");
   a_other_fault_off: assert property (
      OTHER_FAULT_I |=> !OUTPUT_EN_O)
      else $error("output on during other fault");
   a_cmd_off_low: assert property (!ENABLE_REQ_I |=> !OUTPUT_EN_O)
      else $error("output on while commanded off");
   a_fault_sticky: assert property (
      OT_FAULT_O && !wr_now && !$past(wr_now) |=> OT_FAULT_O)
      else $error("fault status dropped without clear");
   a_disable_on_fault: assert property (
      $rose(OT_FAULT_O) && act_q[`TFR_ACT_SEL] >= `TFR_SEL_DIS_RETRY
      |-> !OUTPUT_EN_O)
      else $error("output on after disabling fault");
endmodule // tfr_top_assertions

bind tfr_top tfr_top_assertions #(.UNIT_CYCLES(UNIT_CYCLES))
   i_tfr_top_assertions (
   .SYS_CLK_I(SYS_CLK_I), .RST_B_I(RST_B_I), .CMD_VALID_I(CMD_VALID_I),
   .CMD_WRITE_I(CMD_WRITE_I), .CMD_CODE_I(CMD_CODE_I),
   .CMD_WDATA_I(CMD_WDATA_I), .TEMP_I(TEMP_I), .ENABLE_REQ_I(ENABLE_REQ_I),
   .OTHER_FAULT_I(OTHER_FAULT_I), .RDATA_O(RDATA_O),
   .RDATA_VALID_O(RDATA_VALID_O), .OUTPUT_EN_O(OUTPUT_EN_O),
   .OT_FAULT_O(OT_FAULT_O), .OT_WARN_O(OT_WARN_O), .UT_WARN_O(UT_WARN_O)
);
`default_nettype wire

/* File: test/tfr_host_model.sv */
// Purpose: Host side issuing decoded management commands
// Assumes: One command per call, driven just after a rising edge
// Notes:   Released lines show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none

module tfr_host_model (
   input  wire logic        clk_i,
   input  wire logic [15:0] rdata_i,
   input  wire logic        rdata_valid_i,
   output logic             valid_o,
   output logic             write_o,
   output logic [7:0]       code_o,
   output logic [15:0]      wdata_o
);
   initial begin
      valid_o = 1'b0;
      write_o = 1'b0;
      code_o  = 8'h00;
      wdata_o = 16'h0000;
   end

   task automatic xfer(input logic w, input logic [7:0] c,
                       input logic [15:0] v, output logic [15:0] r);
      @(posedge clk_i);
      valid_o <= 1'b1;
      write_o <= w;
      code_o  <= c;
      wdata_o <= v;
      @(posedge clk_i);
      valid_o <= 1'b0;
      write_o <= ~w;
      code_o  <= ~c;
      wdata_o <= ~v;
      r = 16'hxxxx;
      if (!w) begin
         @(posedge clk_i);
         if (rdata_valid_i) r = rdata_i;
      end
   endtask
endmodule // tfr_host_model
`default_nettype wire

/* File: test/temperature_fault_response_test.sv */
// Purpose: Self-checking bench for the temperature fault block
// Assumes: Delay unit shortened to UNIT clock cycles
// Notes:   A reference array predicts reads; output levels are fixed per step
`timescale 1ns/1ps
`include "tfr_regs.svh"
`default_nettype none

module temperature_fault_response_test;
   import tfr_pkg::*;
   localparam int unsigned UNIT = 4;
   localparam logic [15:0] HOT  = 16'h00c8;
   localparam logic [15:0] MILD = 16'h0019;
   localparam logic [15:0] COLD = 16'h0700;
   logic        clk, rst_b, valid, write, rvalid, en, ofl;
   logic        out_en, ot_fault, ot_warn, ut_warn;
   logic [7:0]  code;
   logic [15:0] wdata, temp, rdata, d;
   logic [15:0] mdl [256];
   logic [31:0] seed;
   int          miscompares, num_checks, cycles, n;
   logic [7:0]  codes [6] = '{8'h4f, 8'h50, 8'h51, 8'h52, 8'h7d, 8'h60};

   tfr_top #(.UNIT_CYCLES(UNIT)) i_tfr_top (
      .SYS_CLK_I(clk), .RST_B_I(rst_b), .CMD_VALID_I(valid),
      .CMD_WRITE_I(write), .CMD_CODE_I(code), .CMD_WDATA_I(wdata),
      .TEMP_I(temp), .ENABLE_REQ_I(en), .OTHER_FAULT_I(ofl),
      .RDATA_O(rdata), .RDATA_VALID_O(rvalid), .OUTPUT_EN_O(out_en),
      .OT_FAULT_O(ot_fault), .OT_WARN_O(ot_warn), .UT_WARN_O(ut_warn));

   tfr_host_model i_tfr_host_model (
      .clk_i(clk), .rdata_i(rdata), .rdata_valid_i(rvalid), .valid_o(valid),
      .write_o(write), .code_o(code), .wdata_o(wdata));

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // Linear value scaled by two to the sixteenth
   function automatic longint lin(input logic [15:0] v);
      longint m;
      int     e;
      m = longint'($signed(v[10:0]));
      e = int'($signed(v[15:11]));
      return m <<< (e + 16);
   endfunction

   // Status bits 7/6/5 expected for a steady temperature
   function automatic logic [15:0] sts_exp(input logic [15:0] t);
      logic [15:0] s;
      s = 16'h0000;
      s[7] = lin(t) > lin(mdl[8'h4f]);
      s[6] = lin(t) > lin(mdl[8'h51]);
      s[5] = lin(t) < lin(mdl[8'h52]);
      return s;
   endfunction

   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask

   task automatic chk_out(input logic exp);
      check(16'(out_en), 16'(exp));
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
   endtask

   task automatic set_in(input logic [15:0] t, input logic e, input logic o);
      @(posedge clk);
      temp <= t;
      en   <= e;
      ofl  <= o;
   endtask

   task automatic wr(input logic [7:0] c, input logic [15:0] v);
      i_tfr_host_model.xfer(1'b1, c, v, d);
      if (c == 8'h50) mdl[c] = {8'h00, v[7:0]};
      if (c inside {8'h4f, 8'h51, 8'h52}) mdl[c] = v;
   endtask

   task automatic rd(input logic [7:0] c);
      i_tfr_host_model.xfer(1'b0, c, 16'h0000, d);
      check(d, mdl[c]);
   endtask

   task automatic clear_all();
      wr(8'h03, 16'h0000);
      mdl[8'h7d] = 16'h0000;
      cyc(3);
   endtask

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 8000) begin
         miscompares++;
         conclude();
      end
   end

   initial begin
      rst_b = 1'b0;
      temp = MILD;
      en = 1'b0;
      ofl = 1'b0;
      seed = 32'h000044c3;
      cycles = 0;
      miscompares = 0;
      num_checks = 0;
      mdl = '{default: 16'h0000};
      mdl[8'h4f] = `TFR_RST_OT_FAULT_THR;
      mdl[8'h50] = {8'h00, `TFR_RST_ACTION};
      mdl[8'h51] = `TFR_RST_OT_WARN_THR;
      mdl[8'h52] = `TFR_RST_UT_WARN_THR;
      cyc(10);
      rst_b <= 1'b1;
      foreach (codes[i]) rd(codes[i]);
      foreach (codes[i]) begin
         wr(codes[i], 16'(rnd()));
         if (codes[i] == 8'h7d) mdl[8'h7d] = sts_exp(MILD);
         rd(codes[i]);
      end
      wr(8'h4f, `TFR_RST_OT_FAULT_THR);
      wr(8'h51, `TFR_RST_OT_WARN_THR);
      wr(8'h52, `TFR_RST_UT_WARN_THR);
      clear_all();
      $display("test registers done");
      wr(8'h50, 16'h0000);
      set_in(HOT, 1'b1, 1'b0);
      cyc(40);
      chk_out(1'b1);
      check(16'({ot_fault, ot_warn, ut_warn}), sts_exp(HOT) >> 5);
      set_in(COLD, 1'b1, 1'b0);
      cyc(4);
      mdl[8'h7d] = sts_exp(HOT) | sts_exp(COLD);
      rd(8'h7d);
      chk_out(1'b1);
      set_in(MILD, 1'b1, 1'b0);
      clear_all();
      rd(8'h7d);
      $display("test ignore done");
      for (int k = 0; k < 4; k++) begin
         wr(8'h50, 16'(8'h40 + (k << 3) + k));
         set_in(HOT, 1'b1, 1'b0);
         cyc((UNIT << k) - 1);
         chk_out(1'b1);
         cyc(8);
         chk_out(1'b0);
         set_in(MILD, 1'b0, 1'b0);
         set_in(MILD, 1'b1, 1'b0);
         cyc(3);
         chk_out(1'b1);
         clear_all();
      end
      $display("test delayed done");
      for (int j = 0; j < 2; j++) begin
         wr(8'h50, j ? 16'h0080 : 16'h00c0);
         set_in(HOT, 1'b1, 1'b0);
         cyc(4);
         chk_out(1'b0);
         set_in(MILD, 1'b1, 1'b0);
         cyc(30);
         chk_out(1'b0);
         wr(j ? 8'h03 : 8'h7d, 16'h0080);
         cyc(3);
         chk_out(1'b1);
         clear_all();
      end
      $display("test latch done");
      n = 1 + int'(rnd() % 6);
      wr(8'h50, 16'(8'h81 + (n << 3)));
      set_in(HOT, 1'b1, 1'b0);
      cyc(4);
      set_in(MILD, 1'b1, 1'b0);
      chk_out(1'b0);
      cyc(2 * UNIT + 4);
      chk_out(1'b1);
      set_in(HOT, 1'b1, 1'b0);
      cyc(4 + (n + 3) * 2 * UNIT);
      set_in(MILD, 1'b1, 1'b0);
      cyc(20);
      chk_out(1'b0);
      clear_all();
      chk_out(1'b1);
      $display("test retry count done");
      wr(8'h50, 16'h00b8);
      set_in(HOT, 1'b1, 1'b0);
      cyc(80);
      set_in(MILD, 1'b1, 1'b0);
      cyc(12);
      chk_out(1'b1);
      set_in(HOT, 1'b1, 1'b0);
      cyc(10);
      set_in(HOT, 1'b1, 1'b1);
      cyc(2);
      chk_out(1'b0);
      set_in(MILD, 1'b1, 1'b0);
      cyc(30);
      chk_out(1'b0);
      clear_all();
      chk_out(1'b1);
      $display("test retry forever done");
      conclude();
   end
endmodule // temperature_fault_response_test
`default_nettype wire
